// >>> rtl/event_log_cfg.svh
// Offsets, field positions and reset values of the event log block
// Assumes an AXI4-Lite master with 32-bit data and aligned word accesses
`ifndef EVENT_LOG_CFG_SVH
`define EVENT_LOG_CFG_SVH
`define OFS_READ_LOG        12'h000
`define OFS_WRITE_LOG       12'h004
`define OFS_STATUS          12'h008
`define OFS_MASK            12'h00C
`define OFS_RESET_STATUS    12'h010
`define OFS_CONTROL         12'h014
`define BIT_TIMEOUT         3
`define BIT_ERROR           2
`define BIT_ISO_ACC         1
`define BIT_RST_ACC         0
`define BIT_ACT_WRITE       1
`define BIT_ACT_READ        0
`define EVENT_W             4
`define MASK_RESET          4'h0
`define STATUS_RESET        4'h0
`define LOG_RESET           32'h0000_0000
`define RESP_OKAY           2'h0
`define RESP_SLVERR         2'h2
`endif

// >>> rtl/event_log_pkg.sv
// Types shared by the event log block
// Assumes event_log_cfg.svh is compiled alongside
package event_log_pkg;
    typedef struct packed {
        logic [23:0] txn_id;
        logic [7:0]  node_id;
    } id_log_s;
    typedef struct packed {
        logic valid;
        logic [23:0] txn_id;
        logic [7:0]  node_id;
    } req_s;
endpackage

// >>> rtl/isolation_monitor_event_log.sv
// Soft reset access log, event status, mask and interrupt, AXI4-Lite slave
// Assumes requester strobes and event pulses come from logic on aclk
`timescale 1ns/100ps
`include "event_log_cfg.svh"
module isolation_monitor_event_log (
    input  wire logic                     aclk,
    input  wire logic                     aresetn,
    input  wire logic [11:0]              s_awaddr,
    input  wire logic                     s_awvalid,
    output logic                          s_awready,
    input  wire logic [31:0]              s_wdata,
    input  wire logic [3:0]               s_wstrb,
    input  wire logic                     s_wvalid,
    output logic                          s_wready,
    output logic [1:0]                    s_bresp,
    output logic                          s_bvalid,
    input  wire logic                     s_bready,
    input  wire logic [11:0]              s_araddr,
    input  wire logic                     s_arvalid,
    output logic                          s_arready,
    output logic [31:0]                   s_rdata,
    output logic [1:0]                    s_rresp,
    output logic                          s_rvalid,
    input  wire logic                     s_rready,
    input  wire event_log_pkg::req_s      read_req,
    input  wire event_log_pkg::req_s      write_req,
    input  wire logic                     read_done,
    input  wire logic                     write_done,
    input  wire logic                     soft_reset_active,
    input  wire logic                     monitor_closed,
    input  wire logic                     isolation_active,
    input  wire logic                     timeout_detect,
    input  wire logic                     error_detect,
    output logic                          irq
);
    event_log_pkg::id_log_s read_log_reg;
    event_log_pkg::id_log_s write_log_reg;
    logic [3:0]  status_reg;
    logic [3:0]  status_next;
    logic [3:0]  mask_reg;
    logic [7:0]  rd_count_reg;
    logic [7:0]  wr_count_reg;
    logic        rd_logged_reg;
    logic        wr_logged_reg;
    logic        srst_q_reg;
    logic        aw_held_reg;
    logic        w_held_reg;
    logic [11:0] awaddr_reg;
    logic [31:0] wdata_reg;
    logic        bvalid_reg;
    logic [1:0]  bresp_reg;
    logic        rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0]  rresp_reg;
    logic        irq_reg;
    logic        s_wstrb_ok;
    logic [3:0]  wstrb_reg;

    function automatic logic [9:0] word_sel(input logic [11:0] a);
        word_sel = a[11:2];
    endfunction

    // Activity counters; an issue and a completion in one cycle cancel
    wire        active_read  = (rd_count_reg != 8'h00);
    wire        active_write = (wr_count_reg != 8'h00);
    wire        srst_entry   = soft_reset_active && !srst_q_reg;
    wire        cap_read     = read_req.valid && soft_reset_active
                               && (!rd_logged_reg || srst_entry);
    wire        cap_write    = write_req.valid && soft_reset_active
                               && (!wr_logged_reg || srst_entry);
    wire        closed_hit   = monitor_closed && (read_req.valid || write_req.valid);

    // Write path: address and data may come in either order
    wire        aw_have  = aw_held_reg || s_awvalid;
    wire        w_have   = w_held_reg || s_wvalid;
    wire        wr_fire  = aw_have && w_have && !bvalid_reg;
    wire [11:0] wr_addr  = aw_held_reg ? awaddr_reg : s_awaddr;
    wire [31:0] wr_data  = w_held_reg ? wdata_reg : s_wdata;
    wire [9:0]  wr_idx   = word_sel(wr_addr);
    wire        wr_stat  = wr_fire && (wr_idx == word_sel(`OFS_STATUS)) && s_wstrb_ok;
    wire        wr_mask  = wr_fire && (wr_idx == word_sel(`OFS_MASK)) && s_wstrb_ok;
    wire        wr_known = (wr_idx <= word_sel(`OFS_CONTROL));
    assign s_wstrb_ok = w_held_reg ? wstrb_reg[0] : s_wstrb[0];

    assign s_awready = !aw_held_reg && !bvalid_reg;
    assign s_wready  = !w_held_reg && !bvalid_reg;
    assign s_bvalid  = bvalid_reg;
    assign s_bresp   = bresp_reg;

    // Read path
    wire        rd_fire  = s_arvalid && !rvalid_reg;
    wire [9:0]  rd_idx   = word_sel(s_araddr);
    assign s_arready = !rvalid_reg;
    assign s_rvalid  = rvalid_reg;
    assign s_rdata   = rdata_reg;
    assign s_rresp   = rresp_reg;

    logic [31:0] rd_word;
    logic        rd_known;
    always_comb begin
        rd_known = 1'b1;
        case (rd_idx)
            word_sel(`OFS_READ_LOG):     rd_word = read_log_reg;
            word_sel(`OFS_WRITE_LOG):    rd_word = write_log_reg;
            word_sel(`OFS_STATUS):       rd_word = {28'h000_0000, status_reg};
            word_sel(`OFS_MASK):         rd_word = {28'h000_0000, mask_reg};
            word_sel(`OFS_RESET_STATUS): rd_word = {30'h0000_0000, active_write, active_read};
            word_sel(`OFS_CONTROL):      rd_word = {31'h0000_0000, srst_q_reg};
            default: begin
                rd_word  = 32'h0000_0000;
                rd_known = 1'b0;
            end
        endcase
    end

    // Hardware set wins over a same-cycle software clear
    wire [3:0] ev_set = {timeout_detect,
                         error_detect,
                         closed_hit && isolation_active,
                         closed_hit && !isolation_active};
    wire [3:0] ev_clr = wr_stat ? wr_data[3:0] : 4'h0;
    assign status_next = (status_reg & ~ev_clr) | ev_set;
    assign irq = irq_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            status_reg <= `STATUS_RESET;
            mask_reg   <= `MASK_RESET;
            irq_reg    <= 1'b0;
        end else begin
            status_reg <= status_next;
            if (wr_mask) begin
                mask_reg <= wr_data[3:0];
            end
            irq_reg <= |(status_next & ~(wr_mask ? wr_data[3:0] : mask_reg));
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rd_count_reg  <= 8'h00;
            wr_count_reg  <= 8'h00;
            srst_q_reg    <= 1'b0;
            rd_logged_reg <= 1'b0;
            wr_logged_reg <= 1'b0;
            read_log_reg  <= `LOG_RESET;
            write_log_reg <= `LOG_RESET;
        end else begin
            rd_count_reg <= rd_count_reg + 8'(read_req.valid) - 8'(read_done && active_read);
            wr_count_reg <= wr_count_reg + 8'(write_req.valid) - 8'(write_done && active_write);
            srst_q_reg   <= soft_reset_active;
            // Re-entry to soft reset re-arms both logs
            if (srst_entry) begin
                rd_logged_reg <= 1'b0;
                wr_logged_reg <= 1'b0;
            end
            if (cap_read) begin
                read_log_reg  <= {read_req.txn_id, read_req.node_id};
                rd_logged_reg <= 1'b1;
            end
            if (cap_write) begin
                write_log_reg <= {write_req.txn_id, write_req.node_id};
                wr_logged_reg <= 1'b1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_reg <= 1'b0;
            w_held_reg  <= 1'b0;
            awaddr_reg  <= 12'h000;
            wdata_reg   <= 32'h0000_0000;
            wstrb_reg   <= 4'h0;
            bvalid_reg  <= 1'b0;
            bresp_reg   <= `RESP_OKAY;
        end else begin
            if (s_awvalid && s_awready && !wr_fire) begin
                aw_held_reg <= 1'b1;
                awaddr_reg  <= s_awaddr;
            end
            if (s_wvalid && s_wready && !wr_fire) begin
                w_held_reg <= 1'b1;
                wdata_reg  <= s_wdata;
                wstrb_reg  <= s_wstrb;
            end
            if (wr_fire) begin
                aw_held_reg <= 1'b0;
                w_held_reg  <= 1'b0;
                bvalid_reg  <= 1'b1;
                bresp_reg   <= wr_known ? `RESP_OKAY : `RESP_SLVERR;
            end else if (bvalid_reg && s_bready) begin
                bvalid_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_reg <= 1'b0;
            rdata_reg  <= 32'h0000_0000;
            rresp_reg  <= `RESP_OKAY;
        end else if (rd_fire) begin
            rvalid_reg <= 1'b1;
            rdata_reg  <= rd_word;
            rresp_reg  <= rd_known ? `RESP_OKAY : `RESP_SLVERR;
        end else if (rvalid_reg && s_rready) begin
            rvalid_reg <= 1'b0;
        end
    end

    sequence srst_enter_s;
        soft_reset_active && !srst_q_reg;
    endsequence
    sequence read_arrive_s;
        read_req.valid && soft_reset_active;
    endsequence
    sequence write_arrive_s;
        write_req.valid && soft_reset_active;
    endsequence

    read_log_a: assert property (@(posedge aclk) disable iff (!aresetn)
        cap_read |=> read_log_reg.txn_id == $past(read_req.txn_id))
        else $error("Read ID not logged");
    read_node_a: assert property (@(posedge aclk) disable iff (!aresetn)
        cap_read |=> read_log_reg.node_id == $past(read_req.node_id))
        else $error("Read node ID not logged");
    write_log_a: assert property (@(posedge aclk) disable iff (!aresetn)
        cap_write |=> write_log_reg.txn_id == $past(write_req.txn_id))
        else $error("Write ID not logged");
    write_node_a: assert property (@(posedge aclk) disable iff (!aresetn)
        cap_write |=> write_log_reg.node_id == $past(write_req.node_id))
        else $error("Write node ID not logged");
    log_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (rd_logged_reg && soft_reset_active && srst_q_reg) |=> $stable(read_log_reg))
        else $error("Read log overwritten");
    timeout_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
        timeout_detect |=> status_reg[`BIT_TIMEOUT])
        else $error("Timeout event lost");
    error_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
        error_detect |=> status_reg[`BIT_ERROR])
        else $error("Error event lost");
    closed_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
        closed_hit |=> (status_reg[`BIT_ISO_ACC] || status_reg[`BIT_RST_ACC]))
        else $error("Closed access event lost");
    clear_one_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (wr_stat && wr_data[0] && !ev_set[0]) |=> !status_reg[0])
        else $error("Write one did not clear");
    sticky_bit_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (status_reg[2] && !ev_clr[2]) |=> status_reg[2])
        else $error("Pending bit dropped");
    irq_level_a: assert property (@(posedge aclk) disable iff (!aresetn)
        irq == |(status_reg & ~mask_reg))
        else $error("Interrupt level mismatch");
    mask_quiet_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (mask_reg == 4'hF) |-> ##1 (mask_reg != 4'hF || !irq))
        else $error("Masked event raised interrupt");
    mask_write_a: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_mask |=> mask_reg == $past(wr_data[3:0]))
        else $error("Mask write lost");
    irq_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (|(status_reg & ~mask_reg) && !wr_fire && ev_clr == 4'h0) |=> irq)
        else $error("Interrupt dropped while pending");
    wr_active_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (write_req.valid && !write_done) |=> active_write)
        else $error("Write activity not shown");
    rd_active_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (read_req.valid && !read_done) |=> active_read)
        else $error("Read activity not shown");
    rearm_read_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (srst_enter_s ##0 !read_req.valid) |=> !rd_logged_reg)
        else $error("Read log not re-armed");
    rearm_write_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (srst_enter_s ##0 !write_req.valid) |=> !wr_logged_reg)
        else $error("Write log not re-armed");
    first_read_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (srst_enter_s ##0 read_arrive_s) |=> rd_logged_reg)
        else $error("Read at entry not logged");
    first_write_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (srst_enter_s ##0 write_arrive_s) |=> wr_logged_reg)
        else $error("Write at entry not logged");
    write_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (wr_logged_reg && soft_reset_active && srst_q_reg) |=> $stable(write_log_reg))
        else $error("Write log overwritten");
    iso_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (closed_hit && isolation_active) |=> status_reg[`BIT_ISO_ACC])
        else $error("Isolation access event lost");
    rst_acc_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (closed_hit && !isolation_active) |=> status_reg[`BIT_RST_ACC])
        else $error("Reset access event lost");
    iso_quiet_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (!closed_hit && !status_reg[`BIT_ISO_ACC]) |=> !status_reg[`BIT_ISO_ACC])
        else $error("Isolation access bit set idly");
    rst_quiet_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (!closed_hit && !status_reg[`BIT_RST_ACC]) |=> !status_reg[`BIT_RST_ACC])
        else $error("Reset access bit set idly");
    timeout_quiet_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (!timeout_detect && !status_reg[`BIT_TIMEOUT]) |=> !status_reg[`BIT_TIMEOUT])
        else $error("Timeout bit set idly");
    error_quiet_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (!error_detect && !status_reg[`BIT_ERROR]) |=> !status_reg[`BIT_ERROR])
        else $error("Error bit set idly");
    set_wins_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (timeout_detect && ev_clr[`BIT_TIMEOUT]) |=> status_reg[`BIT_TIMEOUT])
        else $error("Clear beat timeout set");
    error_wins_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (error_detect && ev_clr[`BIT_ERROR]) |=> status_reg[`BIT_ERROR])
        else $error("Clear beat error set");
    clear_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (wr_stat && !wr_data[3] && status_reg[3]) |=> status_reg[3])
        else $error("Write zero cleared a bit");
    clear_all_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (wr_stat && wr_data[3:0] == 4'hF && !timeout_detect && !error_detect && !closed_hit)
        |=> status_reg == 4'h0)
        else $error("Write ones left bits set");
    no_event_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (ev_set == 4'h0 && !wr_stat) |=> status_reg == $past(status_reg))
        else $error("Status moved without cause");
    mask_keep_a: assert property (@(posedge aclk) disable iff (!aresetn)
        !wr_mask |=> $stable(mask_reg))
        else $error("Mask moved without write");
    mask_one_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (mask_reg[2] && status_reg == 4'h4 && ev_set == 4'h0 && !wr_mask) |=> !irq)
        else $error("Masked error raised interrupt");
    irq_rise_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (timeout_detect && !mask_reg[3] && !wr_mask) |=> irq)
        else $error("Interrupt missed timeout");
    status_rd_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (rd_fire && rd_idx == word_sel(`OFS_STATUS))
        |=> s_rdata == {28'h000_0000, $past(status_reg)})
        else $error("Status read wrong");
    mask_rd_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (rd_fire && rd_idx == word_sel(`OFS_MASK))
        |=> s_rdata == {28'h000_0000, $past(mask_reg)})
        else $error("Mask read wrong");
    rlog_rd_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (rd_fire && rd_idx == word_sel(`OFS_READ_LOG)) |=> s_rdata == $past(read_log_reg))
        else $error("Read log read wrong");
    wlog_rd_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (rd_fire && rd_idx == word_sel(`OFS_WRITE_LOG)) |=> s_rdata == $past(write_log_reg))
        else $error("Write log read wrong");
    act_rd_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (rd_fire && rd_idx == word_sel(`OFS_RESET_STATUS))
        |=> s_rdata == {30'h0000_0000, $past(active_write), $past(active_read)})
        else $error("Activity read wrong");
    rd_idle_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (!active_read && !read_req.valid) |=> !active_read)
        else $error("Read activity without read");
    wr_idle_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (!active_write && !write_req.valid) |=> !active_write)
        else $error("Write activity without write");
endmodule // isolation_monitor_event_log

// >>> tb/requester_model.sv
// Upstream requester model: starts reads and writes, finishes them later
// Assumes one pulse of rd_go or wr_go at a time in each direction
`timescale 1ns/100ps
module requester_model (
    input  wire logic                aclk,
    input  wire logic                rd_go,
    input  wire logic                wr_go,
    input  wire event_log_pkg::req_s req_in,
    input  wire logic [7:0]          lat,
    output event_log_pkg::req_s      read_req,
    output event_log_pkg::req_s      write_req,
    output logic                     read_done,
    output logic                     write_done
);
    logic [7:0] rd_cnt = 8'h00;
    logic [7:0] wr_cnt = 8'h00;
    // Idle bus shows inverted ID so a stale capture cannot pass
    always @(posedge aclk) begin
        read_req <= rd_go ? req_in : {1'b0, ~req_in[31:0]};
        write_req <= wr_go ? req_in : {1'b0, ~req_in[31:0]};
        rd_cnt <= rd_go ? lat : (rd_cnt != 8'h00) ? rd_cnt - 8'h01 : rd_cnt;
        wr_cnt <= wr_go ? lat : (wr_cnt != 8'h00) ? wr_cnt - 8'h01 : wr_cnt;
        read_done <= rd_cnt == 8'h01;
        write_done <= wr_cnt == 8'h01;
    end
endmodule // requester_model

// >>> tb/test_isolation_monitor_event_log.sv
// Bench for the event log block: AXI4-Lite tasks and event stimulus
// Assumes requester_model stands in for the upstream requesters
`timescale 1ns/100ps
`include "event_log_cfg.svh"
module test_isolation_monitor_event_log;
    logic                aclk = 1'b0;
    logic                aresetn = 1'b0;
    logic [11:0]         s_awaddr = 12'h000;
    logic [11:0]         s_araddr = 12'h000;
    logic [31:0]         s_wdata = 32'h0000_0000;
    logic [3:0]          s_wstrb = 4'hF;
    logic                s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0;
    logic                s_arvalid = 1'b0, s_rready = 1'b0;
    logic                s_awready, s_wready, s_bvalid, s_arready, s_rvalid, irq;
    logic [1:0]          s_bresp, s_rresp, resp;
    logic [31:0]         s_rdata, rd;
    logic                rd_go = 1'b0, wr_go = 1'b0, read_done, write_done;
    logic                soft_reset_active = 1'b0, monitor_closed = 1'b0;
    logic                isolation_active = 1'b0;
    logic                timeout_detect = 1'b0, error_detect = 1'b0;
    logic [7:0]          lat = 8'h3C;
    event_log_pkg::req_s req_in = '0, read_req, write_req;
    int                  err_count = 0, n_checks = 0;

    isolation_monitor_event_log u_isolation_monitor_event_log (.aclk, .aresetn, .s_awaddr,
        .s_awvalid, .s_awready, .s_wdata, .s_wstrb, .s_wvalid, .s_wready, .s_bresp, .s_bvalid,
        .s_bready, .s_araddr, .s_arvalid, .s_arready, .s_rdata, .s_rresp, .s_rvalid, .s_rready,
        .read_req, .write_req, .read_done, .write_done, .soft_reset_active, .monitor_closed,
        .isolation_active, .timeout_detect, .error_detect, .irq);
    requester_model u_requester_model (.aclk, .rd_go, .wr_go, .req_in, .lat, .read_req,
        .write_req, .read_done, .write_done);

    initial begin
        forever #12.5 aclk = ~aclk;
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // Handshakes judged in the half cycle before the edge, released after it
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic aw_ok, w_ok, b_ok;
        b_ok = 1'b0;
        s_awaddr <= a;
        s_wdata <= d;
        s_awvalid <= 1'b1;
        s_wvalid <= 1'b1;
        s_bready <= 1'b1;
        while (!b_ok) begin
            @(negedge aclk);
            aw_ok = s_awvalid && s_awready;
            w_ok = s_wvalid && s_wready;
            b_ok = s_bvalid && s_bready;
            resp = s_bresp;
            @(posedge aclk);
            if (aw_ok) s_awvalid <= 1'b0;
            if (w_ok) s_wvalid <= 1'b0;
            if (b_ok) s_bready <= 1'b0;
        end
        @(posedge aclk);
    endtask

    task automatic rdr(input logic [11:0] a);
        logic ar_ok, r_ok;
        r_ok = 1'b0;
        s_araddr <= a;
        s_arvalid <= 1'b1;
        s_rready <= 1'b1;
        while (!r_ok) begin
            @(negedge aclk);
            ar_ok = s_arvalid && s_arready;
            r_ok = s_rvalid && s_rready;
            rd = s_rdata;
            resp = s_rresp;
            @(posedge aclk);
            if (ar_ok) s_arvalid <= 1'b0;
            if (r_ok) s_rready <= 1'b0;
        end
        @(posedge aclk);
    endtask

    task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
        rdr(a);
        check(rd, exp);
    endtask

    // Irq is registered from status_next, in step with status; still wait two edges before sampling
    task automatic ck_irq(input logic e);
        repeat (2) @(posedge aclk);
        @(negedge aclk);
        check({31'h0000_0000, irq}, {31'h0000_0000, e});
        @(posedge aclk);
    endtask

    task automatic issue(input logic r, input logic [23:0] id, input logic [7:0] node);
        req_in <= {1'b1, id, node};
        rd_go <= r;
        wr_go <= !r;
        @(posedge aclk);
        rd_go <= 1'b0;
        wr_go <= 1'b0;
        @(posedge aclk);
    endtask

    task automatic pulse(input logic t, input logic e);
        timeout_detect <= t;
        error_detect <= e;
        @(posedge aclk);
        timeout_detect <= 1'b0;
        error_detect <= 1'b0;
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    initial begin
        repeat (2000) @(posedge aclk);
        err_count++;
        conclude();
    end

    initial begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rchk(`OFS_STATUS, 32'h0000_0000);
        rchk(`OFS_MASK, 32'h0000_0000);
        rchk(`OFS_READ_LOG, 32'h0000_0000);
        rdr(12'h100);
        check({30'h0000_0000, resp}, {30'h0000_0000, `RESP_SLVERR});
        $display("reset values done");
        soft_reset_active <= 1'b1;
        issue(1'b1, 24'h12_3456, 8'h5A);
        issue(1'b0, 24'h65_4321, 8'h0C);
        rchk(`OFS_RESET_STATUS, 32'h0000_0003);
        rchk(`OFS_CONTROL, 32'h0000_0001);
        repeat (70) @(posedge aclk);
        rchk(`OFS_RESET_STATUS, 32'h0000_0000);
        issue(1'b1, 24'hAB_CDEF, 8'h33);
        issue(1'b0, 24'hFE_DCBA, 8'h44);
        rchk(`OFS_READ_LOG, 32'h1234_565A);
        rchk(`OFS_WRITE_LOG, 32'h6543_210C);
        wr(`OFS_READ_LOG, 32'hFFFF_FFFF);
        rchk(`OFS_READ_LOG, 32'h1234_565A);
        repeat (70) @(posedge aclk);
        soft_reset_active <= 1'b0;
        @(posedge aclk);
        soft_reset_active <= 1'b1;
        issue(1'b1, 24'h00_0001, 8'h01);
        rchk(`OFS_READ_LOG, 32'h0000_0101);
        soft_reset_active <= 1'b0;
        $display("reset log done");
        pulse(1'b1, 1'b0);
        rchk(`OFS_STATUS, 32'h0000_0008);
        ck_irq(1'b1);
        pulse(1'b0, 1'b1);
        rchk(`OFS_STATUS, 32'h0000_000C);
        monitor_closed <= 1'b1;
        isolation_active <= 1'b1;
        issue(1'b1, 24'h00_0002, 8'h02);
        @(posedge aclk);
        isolation_active <= 1'b0;
        issue(1'b0, 24'h00_0003, 8'h03);
        @(posedge aclk);
        monitor_closed <= 1'b0;
        rchk(`OFS_STATUS, 32'h0000_000F);
        $display("events done");
        wr(`OFS_MASK, 32'hFFFF_FFFF);
        rchk(`OFS_MASK, 32'h0000_000F);
        ck_irq(1'b0);
        rchk(`OFS_STATUS, 32'h0000_000F);
        wr(`OFS_MASK, 32'h0000_0007);
        ck_irq(1'b1);
        wr(`OFS_STATUS, 32'h0000_0005);
        rchk(`OFS_STATUS, 32'h0000_000A);
        wr(`OFS_STATUS, 32'h0000_0008);
        ck_irq(1'b0);
        wr(`OFS_MASK, 32'h0000_0000);
        ck_irq(1'b1);
        wr(`OFS_STATUS, 32'h0000_0002);
        ck_irq(1'b0);
        wr(12'h100, 32'h0000_0001);
        check({30'h0000_0000, resp}, {30'h0000_0000, `RESP_SLVERR});
        $display("mask and clear done");
        conclude();
    end
endmodule // test_isolation_monitor_event_log
